// ===== hdl/hrbp_device.sv
// device end of the host register bus port: 64 byte registers behind the pins
// assumes pins come from logic on clock_i, so no synchroniser is needed
//
// Notes on behaviour
// - strap low: msb pin extends five address lines
// - strap high: msb pin is section select
// - strap high: chip select pin is line select
// - address held while latch enable low
// - single format: host selects chip every access
// - drive data from one cycle after read and select go low, until one cycle after either rises
// - capture data on write strobe rising edge
// - reset pin clears device without clock
// - strap picks two-select or single-select format

`timescale 1ns/100ps

module hrbp_device (
   input  wire logic       clock_i,       // port clock
   input  wire logic       reset_n_i,     // synchronous reset
   hrbp_if.device          link,          // processor pins
   input  wire logic [5:0] peek_index_i,  // register to observe
   output logic      [7:0] peek_data_o,   // observed register value
   input  wire logic       upd_valid_i,   // core writes a register
   input  wire logic [5:0] upd_index_i,   // core write index
   input  wire logic [7:0] upd_data_i,    // core write value
   output logic            wr_event_o,    // pulse: processor wrote a register
   output logic      [5:0] wr_index_o,    // index of that write
   output logic      [7:0] wr_data_o,     // value of that write
   output logic            rd_event_o,    // pulse: processor read began
   output logic      [5:0] rd_index_o,    // index of that read
   output logic            legacy_o,      // current format strap
   output logic            dual_select_o  // both layer selects seen low
);

   ////////////////////////////////////////////////////////////////////////////
   // address latch

   logic [hrbp_pkg::ADDR_W-1:0] addr_hold_q;
   wire  [hrbp_pkg::ADDR_W-1:0] addr_live;
   wire  [hrbp_pkg::ADDR_W-1:0] addr_eff;

   assign addr_live = {link.addr_msb, link.addr_low};
   // transparent while enable is high, frozen copy while low
   assign addr_eff  = link.address_latch_en ? addr_live : addr_hold_q;

   always_ff @(posedge clock_i or negedge link.async_reset_n) begin
      if (!link.async_reset_n) begin
         addr_hold_q <= hrbp_pkg::ADDR_RESET;
      end else if (!reset_n_i) begin
         addr_hold_q <= hrbp_pkg::ADDR_RESET;
      end else begin
         addr_hold_q <= addr_eff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // format and select decode

   wire legacy;
   wire section_select_n;
   wire line_select_n;
   wire sec_sel;
   wire line_sel;
   wire single_sel;
   wire selected;
   wire [hrbp_pkg::ADDR_W-1:0] reg_index;

   assign legacy           = link.legacy_bus_format;
   assign section_select_n = link.addr_msb;
   assign line_select_n    = link.chip_sel_n;

   // selects are taken live, never latched, so a select alone can end an access
   assign sec_sel    = legacy & ~section_select_n;
   assign line_sel   = legacy & ~line_select_n;
   assign single_sel = ~legacy & ~link.chip_sel_n;
   assign selected   = single_sel | sec_sel | line_sel;

   // two-select format: section bank low half, line bank high half;
   // should both be low, line wins rather than mixing two registers
   assign reg_index = legacy ? {line_sel, addr_eff[hrbp_pkg::LOW_W-1:0]}
                             : addr_eff;

   ////////////////////////////////////////////////////////////////////////////
   // strobe decode

   logic wr_prev_q;
   wire  read_act;
   wire  write_rise;

   assign read_act   = selected & ~link.read_strobe_n;
   assign write_rise = ~wr_prev_q & link.write_strobe_n & selected;

   always_ff @(posedge clock_i or negedge link.async_reset_n) begin
      if (!link.async_reset_n) begin
         wr_prev_q <= 1'b1;
      end else if (!reset_n_i) begin
         wr_prev_q <= 1'b1;
      end else begin
         wr_prev_q <= link.write_strobe_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register storage

   logic [hrbp_pkg::DATA_W-1:0] reg_q [hrbp_pkg::NUM_REGS];

   // a processor write beats a core update to the same register in one cycle
   for (genvar i = 0; i < hrbp_pkg::NUM_REGS; i++) begin : g_reg
      wire bus_hit;
      wire core_hit;

      assign bus_hit  = write_rise && (reg_index == hrbp_pkg::ADDR_W'(i));
      assign core_hit = upd_valid_i && (upd_index_i == hrbp_pkg::ADDR_W'(i));

      always_ff @(posedge clock_i or negedge link.async_reset_n) begin
         if (!link.async_reset_n) begin
            reg_q[i] <= hrbp_pkg::REG_RESET;
         end else if (!reset_n_i) begin
            reg_q[i] <= hrbp_pkg::REG_RESET;
         end else if (bus_hit) begin
            reg_q[i] <= link.data_bus;
         end else if (core_hit) begin
            reg_q[i] <= upd_data_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // data drive back to the processor

   logic [hrbp_pkg::DATA_W-1:0] dout_q;
   logic                        doe_q;

   always_ff @(posedge clock_i or negedge link.async_reset_n) begin
      if (!link.async_reset_n) begin
         dout_q <= hrbp_pkg::REG_RESET;
         doe_q  <= 1'b0;
      end else if (!reset_n_i) begin
         dout_q <= hrbp_pkg::REG_RESET;
         doe_q  <= 1'b0;
      end else begin
         dout_q <= reg_q[reg_index];
         doe_q  <= read_act;
      end
   end

   // one cycle behind the strobe: the price of driving pins from flops
   assign link.dev_data_out = dout_q;
   assign link.dev_data_oe  = doe_q;

   ////////////////////////////////////////////////////////////////////////////
   // core-side reporting

   logic [hrbp_pkg::DATA_W-1:0] peek_q;
   logic                        wr_event_q;
   logic [hrbp_pkg::ADDR_W-1:0] wr_index_q;
   logic [hrbp_pkg::DATA_W-1:0] wr_data_q;
   logic                        rd_event_q;
   logic [hrbp_pkg::ADDR_W-1:0] rd_index_q;
   logic                        legacy_q;
   logic                        dual_q;
   wire                         rd_start;

   assign rd_start = read_act & ~doe_q;

   always_ff @(posedge clock_i or negedge link.async_reset_n) begin
      if (!link.async_reset_n) begin
         peek_q     <= hrbp_pkg::REG_RESET;
         wr_event_q <= 1'b0;
         wr_index_q <= hrbp_pkg::ADDR_RESET;
         wr_data_q  <= hrbp_pkg::REG_RESET;
         rd_event_q <= 1'b0;
         rd_index_q <= hrbp_pkg::ADDR_RESET;
         legacy_q   <= 1'b0;
         dual_q     <= 1'b0;
      end else if (!reset_n_i) begin
         peek_q     <= hrbp_pkg::REG_RESET;
         wr_event_q <= 1'b0;
         wr_index_q <= hrbp_pkg::ADDR_RESET;
         wr_data_q  <= hrbp_pkg::REG_RESET;
         rd_event_q <= 1'b0;
         rd_index_q <= hrbp_pkg::ADDR_RESET;
         legacy_q   <= 1'b0;
         dual_q     <= 1'b0;
      end else begin
         peek_q     <= reg_q[peek_index_i];
         wr_event_q <= write_rise;
         if (write_rise) begin
            wr_index_q <= reg_index;
            wr_data_q  <= link.data_bus;
         end
         rd_event_q <= rd_start;
         if (rd_start) begin
            rd_index_q <= reg_index;
         end
         legacy_q   <= legacy;
         // only flags misuse by the far side, the decode already copes
         dual_q     <= sec_sel & line_sel;
      end
   end

   assign peek_data_o   = peek_q;
   assign wr_event_o    = wr_event_q;
   assign wr_index_o    = wr_index_q;
   assign wr_data_o     = wr_data_q;
   assign rd_event_o    = rd_event_q;
   assign rd_index_o    = rd_index_q;
   assign legacy_o      = legacy_q;
   assign dual_select_o = dual_q;

endmodule

// ===== hdl/hrbp_pkg.sv
// shared constants of the host register bus port: widths, map size, timing
// assumes a single 10 MHz clock common to both ends of the port

package hrbp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // bus shape
   localparam int ADDR_W    = 6;
   localparam int LOW_W     = 5;
   localparam int DATA_W    = 8;
   localparam int NUM_REGS  = 64;
   localparam int MSB_POS   = 5;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [DATA_W-1:0] REG_RESET  = 8'h00;
   localparam logic [DATA_W-1:0] BUS_IDLE   = 8'hff;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 6'h00;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int STROBE_NS     = 300;
   localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] STROBE_LAST = 2'(STROBE_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////
   // host command layer in the two-select format
   localparam logic LAYER_SECTION = 1'b0;
   localparam logic LAYER_LINE    = 1'b1;

endpackage

// ===== hdl/hrbp_if.sv
// pin bundle between the external processor end and the device end
// assumes both ends run on the same clock; the shared data wire is resolved here

`timescale 1ns/100ps

interface hrbp_if;
   logic [4:0] addr_low;           // lower address lines
   logic       addr_msb;           // address msb, or section_select_n in legacy format
   logic       address_latch_en;   // high: address latches transparent
   logic       chip_sel_n;         // chip select, or line_select_n in legacy format
   logic       read_strobe_n;      // read strobe
   logic       write_strobe_n;     // write strobe
   logic       async_reset_n;      // asynchronous device reset
   logic       legacy_bus_format;  // format strap
   logic [7:0] host_data_out;      // processor data drive
   logic       host_data_oe;       // processor drives data wire
   logic [7:0] dev_data_out;       // device data drive
   logic       dev_data_oe;        // device drives data wire
   logic [7:0] data_bus;           // resolved wire level

   // floating wire reads as all ones, like a pulled-up bus
   assign data_bus = host_data_oe ? host_data_out :
                     dev_data_oe  ? dev_data_out  : hrbp_pkg::BUS_IDLE;

   modport device (
      input  addr_low, addr_msb, address_latch_en, chip_sel_n, read_strobe_n,
      input  write_strobe_n, async_reset_n, legacy_bus_format, data_bus,
      output dev_data_out, dev_data_oe
   );

   modport host (
      output addr_low, addr_msb, address_latch_en, chip_sel_n, read_strobe_n,
      output write_strobe_n, async_reset_n, legacy_bus_format,
      output host_data_out, host_data_oe,
      input  data_bus
   );
endinterface

// ===== hdl/hrbp_host.sv
// processor end of the host register bus port: turns commands into pin cycles
// assumes the device end shares clock_i and answers reads one cycle after the strobe

`timescale 1ns/100ps

module hrbp_host (
   input  wire logic       clock_i,      // port clock
   input  wire logic       reset_n_i,    // synchronous reset
   hrbp_if.host            link,         // pins toward the device
   input  wire logic       format_i,     // strap level to present
   input  wire logic       dev_reset_i,  // hold device in reset
   input  wire logic       cmd_valid_i,  // command offered
   input  wire logic       cmd_write_i,  // 1 write, 0 read
   input  wire logic       cmd_layer_i,  // two-select format: 0 section, 1 line
   input  wire logic [5:0] cmd_addr_i,   // register address
   input  wire logic [7:0] cmd_wdata_i,  // write value
   output logic            cmd_ready_o,  // command may be taken
   output logic            rsp_valid_o,  // pulse: command finished
   output logic      [7:0] rsp_rdata_o   // read value
);

   typedef enum {HS_IDLE, HS_ADDR, HS_LATCH, HS_STROBE, HS_RELEASE, HS_DONE} hrbp_hstate_e;

   hrbp_hstate_e state_q;
   logic [1:0]   cnt_q;
   logic         write_q;
   logic         layer_q;
   logic [5:0]   addr_q;
   logic [7:0]   wdata_q;
   logic [4:0]   low_q;
   logic         msb_q;
   logic         ale_q;
   logic         csn_q;
   logic         rdn_q;
   logic         wrn_q;
   logic         rstn_q;
   logic         fmt_q;
   logic [7:0]   dout_q;
   logic         doe_q;
   logic         ready_q;
   logic         rsp_q;
   logic [7:0]   rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // select levels for the strobe phase

   wire sel_msb;
   wire sel_csn;

   // one layer select at a time in the two-select format
   assign sel_msb = fmt_q ? (layer_q != hrbp_pkg::LAYER_SECTION) : addr_q[hrbp_pkg::MSB_POS];
   assign sel_csn = fmt_q ? (layer_q != hrbp_pkg::LAYER_LINE) : 1'b0;

   ////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
         state_q <= HS_IDLE;
         cnt_q   <= 2'h0;
         write_q <= 1'b0;
         layer_q <= 1'b0;
         addr_q  <= hrbp_pkg::ADDR_RESET;
         wdata_q <= hrbp_pkg::REG_RESET;
         low_q   <= 5'h00;
         msb_q   <= 1'b1;
         ale_q   <= 1'b1;
         csn_q   <= 1'b1;
         rdn_q   <= 1'b1;
         wrn_q   <= 1'b1;
         rstn_q  <= 1'b0;
         fmt_q   <= 1'b0;
         dout_q  <= hrbp_pkg::REG_RESET;
         doe_q   <= 1'b0;
         ready_q <= 1'b0;
         rsp_q   <= 1'b0;
         rdata_q <= hrbp_pkg::REG_RESET;
      end else begin
         rstn_q <= ~dev_reset_i;
         rsp_q  <= 1'b0;
         case (state_q)
            HS_IDLE: begin
               // strap only follows format_i between accesses
               fmt_q   <= format_i;
               // a leftover address msb would read as a section select
               msb_q   <= format_i ? 1'b1 : msb_q;
               ready_q <= 1'b1;
               if (cmd_valid_i && ready_q) begin
                  ready_q <= 1'b0;
                  write_q <= cmd_write_i;
                  layer_q <= cmd_layer_i;
                  addr_q  <= cmd_addr_i;
                  wdata_q <= cmd_wdata_i;
                  state_q <= HS_ADDR;
               end
            end
            HS_ADDR: begin
               low_q   <= addr_q[hrbp_pkg::LOW_W-1:0];
               msb_q   <= fmt_q ? 1'b1 : addr_q[hrbp_pkg::MSB_POS];
               ale_q   <= 1'b1;
               state_q <= HS_LATCH;
            end
            HS_LATCH: begin
               ale_q   <= 1'b0;
               state_q <= HS_STROBE;
               cnt_q   <= hrbp_pkg::STROBE_LAST;
               msb_q   <= sel_msb;
               csn_q   <= sel_csn;
               rdn_q   <= write_q;
               wrn_q   <= ~write_q;
               dout_q  <= wdata_q;
               doe_q   <= write_q;
            end
            HS_STROBE: begin
               if (cnt_q == 2'h0) begin
                  if (!write_q) begin
                     rdata_q <= link.data_bus;
                  end
                  rdn_q   <= 1'b1;
                  wrn_q   <= 1'b1;
                  state_q <= HS_RELEASE;
               end else begin
                  cnt_q <= cnt_q - 2'h1;
               end
            end
            HS_RELEASE: begin
               // select and data outlast the strobe edge by a cycle
               csn_q   <= 1'b1;
               msb_q   <= fmt_q ? 1'b1 : msb_q;
               doe_q   <= 1'b0;
               ale_q   <= 1'b1;
               state_q <= HS_DONE;
            end
            HS_DONE: begin
               rsp_q   <= 1'b1;
               state_q <= HS_IDLE;
            end
            default: begin
               state_q <= HS_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   assign link.addr_low          = low_q;
   assign link.addr_msb          = msb_q;
   assign link.address_latch_en  = ale_q;
   assign link.chip_sel_n        = csn_q;
   assign link.read_strobe_n     = rdn_q;
   assign link.write_strobe_n    = wrn_q;
   assign link.async_reset_n     = rstn_q;
   assign link.legacy_bus_format = fmt_q;
   assign link.host_data_out     = dout_q;
   assign link.host_data_oe      = doe_q;
   assign cmd_ready_o            = ready_q;
   assign rsp_valid_o            = rsp_q;
   assign rsp_rdata_o            = rdata_q;

endmodule

// ===== bench/hrbp_chk.sv
// checker for the pins between the processor end and the device end
// assumes one clock for both ends; instantiated beside the interface

`timescale 1ns/100ps

module hrbp_chk (
   input wire logic       clock_i,           // port clock
   input wire logic       reset_n_i,         // sync reset
   input wire logic [4:0] addr_low,          // lower address
   input wire logic       addr_msb,          // msb or section select
   input wire logic       address_latch_en,  // latch enable
   input wire logic       chip_sel_n,        // chip or line select
   input wire logic       read_strobe_n,     // read strobe
   input wire logic       write_strobe_n,    // write strobe
   input wire logic       async_reset_n,     // device reset
   input wire logic       legacy_bus_format, // format strap
   input wire logic [7:0] host_data_out,     // host drive
   input wire logic       host_data_oe,      // host enable
   input wire logic [7:0] dev_data_out,      // device drive
   input wire logic       dev_data_oe        // device enable
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);

   ////////////////////////////////////////////////////////////////////////////
   wire sel_act = legacy_bus_format ? (!addr_msb || !chip_sel_n) : !chip_sel_n;
   wire rd_hit  = !read_strobe_n && sel_act && async_reset_n;

   property p_rd_drive; rd_hit |=> dev_data_oe || !async_reset_n; endproperty
   a_rd_drive: assert property (p_rd_drive) else $error("selected read not driven");
   property p_rd_release; !rd_hit |=> !dev_data_oe; endproperty
   a_rd_release: assert property (p_rd_release) else $error("data driven outside read");
   property p_no_clash; !(host_data_oe && dev_data_oe); endproperty
   a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
   property p_async_clear; !async_reset_n |-> !dev_data_oe; endproperty
   a_async_clear: assert property (p_async_clear) else $error("device drives in reset");
   property p_single_sel; !legacy_bus_format && (!read_strobe_n || !write_strobe_n) |-> !chip_sel_n; endproperty
   a_single_sel: assert property (p_single_sel) else $error("strobe without chip select");
   property p_one_layer; legacy_bus_format |-> addr_msb || chip_sel_n; endproperty
   a_one_layer: assert property (p_one_layer) else $error("both layer selects low");
   // while latch enable is high the section select may not be low
   property p_sec_idle; legacy_bus_format && address_latch_en |-> addr_msb; endproperty
   a_sec_idle: assert property (p_sec_idle) else $error("section select low outside access");
   property p_wr_sel; $rose(write_strobe_n) |-> sel_act; endproperty
   a_wr_sel: assert property (p_wr_sel) else $error("write strobe rose unselected");
   // data must hold over the whole strobe, not just at its rising edge
   property p_wr_hold;
      $fell(write_strobe_n) |-> host_data_oe
         ##1 ($stable(host_data_out) && host_data_oe && !write_strobe_n)[*2] ##1 write_strobe_n;
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write strobe or data unsteady");
   property p_rd_len; $fell(read_strobe_n) |-> !read_strobe_n[*3] ##1 read_strobe_n; endproperty
   a_rd_len: assert property (p_rd_len) else $error("read strobe length wrong");
   property p_addr_hold; (!read_strobe_n || !write_strobe_n) |-> !address_latch_en && $stable(addr_low); endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved during strobe");
   property p_strap_idle; $changed(legacy_bus_format) |-> read_strobe_n && write_strobe_n; endproperty
   a_strap_idle: assert property (p_strap_idle) else $error("strap changed in access");

   ////////////////////////////////////////////////////////////////////////////
   c_legacy_read: cover property (legacy_bus_format && rd_hit);
   c_single_write: cover property (!legacy_bus_format && $rose(write_strobe_n));
   c_async: cover property ($fell(async_reset_n));
   c_legacy_write: cover property (legacy_bus_format && $rose(write_strobe_n));
endmodule

// ===== bench/hrbp_tb.sv
// self-checking bench: host end and device end joined by the pin interface
// assumes the package and interface are compiled first

`timescale 1ns/100ps

module hrbp_tb;
   typedef struct packed {logic fmt; logic wr; logic ly; logic [5:0] ad; logic [7:0] dat; logic [5:0] idx;} hrbp_row_s;
   localparam int NROW = 11;
   // writes check the captured index, reads the answered data
   hrbp_row_s rows [NROW] = '{
      '{1'b0, 1'b1, 1'b0, 6'h3f, 8'ha5, 6'h3f}, '{1'b0, 1'b1, 1'b0, 6'h1f, 8'h5a, 6'h1f},
      '{1'b0, 1'b0, 1'b0, 6'h3f, 8'ha5, 6'h3f}, '{1'b0, 1'b0, 1'b0, 6'h1f, 8'h5a, 6'h1f},
      '{1'b1, 1'b0, 1'b1, 6'h1f, 8'ha5, 6'h3f}, '{1'b1, 1'b0, 1'b0, 6'h1f, 8'h5a, 6'h1f},
      '{1'b1, 1'b1, 1'b0, 6'h00, 8'h3c, 6'h00}, '{1'b1, 1'b1, 1'b1, 6'h00, 8'hc3, 6'h20},
      '{1'b0, 1'b0, 1'b0, 6'h00, 8'h3c, 6'h00}, '{1'b0, 1'b0, 1'b0, 6'h20, 8'hc3, 6'h20},
      '{1'b0, 1'b0, 1'b0, 6'h15, 8'h00, 6'h15}};

   logic       clock_i     = 1'b0;
   logic       reset_n_i   = 1'b0;
   logic       format_i    = 1'b0;
   logic       dev_reset_i = 1'b0;
   logic       cmd_valid_i = 1'b0;
   logic       cmd_write_i = 1'b0;
   logic       cmd_layer_i = 1'b0;
   logic [5:0] cmd_addr_i  = 6'h00;
   logic [7:0] cmd_wdata_i = 8'h00;
   logic [5:0] peek_index_i = 6'h00;
   logic       upd_valid_i = 1'b0;
   logic [5:0] upd_index_i = 6'h00;
   logic [7:0] upd_data_i  = 8'h00;
   logic       cmd_ready_o, rsp_valid_o, legacy_o, dual_select_o, wr_event_o, rd_event_o;
   logic [7:0] rsp_rdata_o, peek_data_o, wr_data_o;
   logic [5:0] wr_index_o, rd_index_o;
   int         miscompares = 0;
   int         total_checks = 0;
   int         wr_count = 0;
   int         rd_count = 0;

   always #50 clock_i = ~clock_i;

   // event pulses last one cycle, so count them mid-cycle where they have settled
   always @(negedge clock_i) begin
      wr_count += int'(wr_event_o === 1'b1);
      rd_count += int'(rd_event_o === 1'b1);
   end

   hrbp_if bus ();
   hrbp_device i_hrbp_device (.clock_i(clock_i), .reset_n_i(reset_n_i), .link(bus), .peek_index_i(peek_index_i),
      .peek_data_o(peek_data_o), .upd_valid_i(upd_valid_i), .upd_index_i(upd_index_i), .upd_data_i(upd_data_i),
      .wr_event_o(wr_event_o), .wr_index_o(wr_index_o), .wr_data_o(wr_data_o), .rd_event_o(rd_event_o),
      .rd_index_o(rd_index_o),
      .legacy_o(legacy_o), .dual_select_o(dual_select_o));
   hrbp_host i_hrbp_host (.clock_i(clock_i), .reset_n_i(reset_n_i), .link(bus), .format_i(format_i),
      .dev_reset_i(dev_reset_i), .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_layer_i(cmd_layer_i),
      .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
      .rsp_rdata_o(rsp_rdata_o));
   hrbp_chk i_hrbp_chk (.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_low(bus.addr_low), .addr_msb(bus.addr_msb),
      .address_latch_en(bus.address_latch_en), .chip_sel_n(bus.chip_sel_n), .read_strobe_n(bus.read_strobe_n),
      .write_strobe_n(bus.write_strobe_n), .async_reset_n(bus.async_reset_n),
      .legacy_bus_format(bus.legacy_bus_format), .host_data_out(bus.host_data_out),
      .host_data_oe(bus.host_data_oe), .dev_data_out(bus.dev_data_out), .dev_data_oe(bus.dev_data_oe));

   ////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         miscompares++;
      end
   endtask

   task automatic issue(input logic wr, input logic ly, input logic [5:0] ad, input logic [7:0] wd);
      int n;
      n = 0;
      while (cmd_ready_o !== 1'b1 && n < 50) begin
         tick(1);
         n++;
      end
      chk({7'h00, cmd_ready_o}, 8'h01);
      cmd_valid_i = 1'b1;
      cmd_write_i = wr;
      cmd_layer_i = ly;
      cmd_addr_i  = ad;
      cmd_wdata_i = wd;
      tick(1);
      cmd_valid_i = 1'b0;
   endtask

   // a lost answer shows up as a failed compare rather than a hang
   task automatic run_cmd(input logic wr, input logic ly, input logic [5:0] ad, input logic [7:0] wd);
      int n;
      issue(wr, ly, ad, wd);
      n = 0;
      while (rsp_valid_o !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      chk({7'h00, rsp_valid_o}, 8'h01);
      tick(1);
   endtask

   task automatic close_out();
      if (miscompares == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      tick(3);
      reset_n_i = 1'b1;
      tick(2);
      for (int i = 0; i < NROW; i++) begin
         format_i = rows[i].fmt;
         tick(2);
         chk({7'h00, legacy_o}, {7'h00, rows[i].fmt});
         run_cmd(rows[i].wr, rows[i].ly, rows[i].ad, rows[i].dat);
         if (rows[i].wr) begin
            chk(wr_data_o, rows[i].dat);
            chk({2'b00, wr_index_o}, {2'b00, rows[i].idx});
         end else begin
            chk(rsp_rdata_o, rows[i].dat);
            chk({2'b00, rd_index_o}, {2'b00, rows[i].idx});
         end
      end
      // reset in mid write: the strobe release in reset must not capture
      issue(1'b1, 1'b0, 6'h2a, 8'h99);
      tick(3);
      reset_n_i = 1'b0;
      tick(3);
      reset_n_i = 1'b1;
      tick(2);
      run_cmd(1'b0, 1'b0, 6'h2a, 8'h00);
      chk(rsp_rdata_o, 8'h00);
      // device reset pin clears registers without a bus cycle
      run_cmd(1'b1, 1'b0, 6'h05, 8'h77);
      peek_index_i = 6'h05;
      tick(2);
      chk(peek_data_o, 8'h77);
      dev_reset_i = 1'b1;
      // cleared right after the pin falls, before any further clock edge
      tick(1);
      chk(peek_data_o, 8'h00);
      tick(2);
      dev_reset_i = 1'b0;
      tick(2);
      run_cmd(1'b0, 1'b0, 6'h05, 8'h00);
      chk(rsp_rdata_o, 8'h00);
      // core update seen by a later bus read
      upd_valid_i = 1'b1;
      upd_index_i = 6'h09;
      upd_data_i  = 8'h4e;
      tick(1);
      upd_valid_i = 1'b0;
      run_cmd(1'b0, 1'b0, 6'h09, 8'h00);
      chk(rsp_rdata_o, 8'h4e);
      chk({7'h00, dual_select_o}, 8'h00);
      // two-select format: each layer select reaches its own bank
      format_i = 1'b1;
      tick(2);
      run_cmd(1'b1, 1'b0, 6'h0a, 8'h66);
      chk({2'b00, wr_index_o}, 8'h0a);
      run_cmd(1'b1, 1'b1, 6'h0a, 8'h99);
      chk({2'b00, wr_index_o}, 8'h2a);
      format_i = 1'b0;
      tick(2);
      run_cmd(1'b0, 1'b0, 6'h0a, 8'h00);
      chk(rsp_rdata_o, 8'h66);
      run_cmd(1'b0, 1'b0, 6'h2a, 8'h00);
      chk(rsp_rdata_o, 8'h99);
      // one event per completed access; the write cut by reset gives none
      chk(8'(wr_count), 8'h07);
      chk(8'(rd_count), 8'h0c);
      close_out();
   end

   initial begin
      #(5000 * 100);
      miscompares++;
      close_out();
   end
endmodule
